/* hdl/imu_pkg.sv */
// Shared constants and types of the host interrupt and command block.
// Assumes a 125 MHz bus clock and whole-word AHB-Lite register access.
package imu_pkg;
   // ==========================================================
   // Register byte offsets.
   localparam logic [7:0] OFS_CMD = 8'h00; // Command code.
   localparam logic [7:0] OFS_CMD_STAT = 8'h04; // Command status.
   localparam logic [7:0] OFS_DATA_STAT = 8'h08; // Data status.
   localparam logic [7:0] OFS_CAL = 8'h0c; // Three operand words.
   localparam logic [7:0] OFS_SENSOR = 8'h18; // Sensor enables.
   localparam logic [7:0] OFS_ACCEL = 8'h1c; // Accel control.
   localparam logic [7:0] OFS_GYRO = 8'h20; // Gyro control.
   localparam logic [7:0] OFS_FIFO = 8'h24; // FIFO control.
   localparam logic [7:0] OFS_LEVEL = 8'h28; // FIFO fill level.
   localparam logic [7:0] OFS_OUT = 8'h2c; // Output sample.
   localparam logic [7:0] OFS_GSCALE = 8'h30; // Gyro scales X..Z.
   localparam logic [7:0] OFS_ASCALE = 8'h3c; // Accel scales X..Z.
   // ==========================================================
   // Field positions and codes.
   localparam int BIT_SENSOR_OFF = 6; // Power-down request.
   localparam int BIT_SYNC_SEL = 7; // Level handshake select.
   localparam int BIT_RATE_TOP = 3; // Slow clock select.
   localparam int BIT_SELFTEST = 7; // Self-test enable.
   localparam int BIT_FIFO_RD = 7; // FIFO read mode.
   localparam logic [1:0] STAB_OIS = 2'b01; // Stabilization mode.
   localparam logic [1:0] STAB_LL = 2'b10; // Low-latency mode.
   localparam logic [1:0] FIFO_STOP = 2'b01; // Stop when full.
   localparam logic [1:0] FIFO_STREAM = 2'b10; // Overwrite oldest.
   localparam logic [7:0] CMD_RST_FIFO = 8'h02;
   localparam logic [7:0] CMD_WAKE = 8'h19;
   localparam logic [7:0] CMD_ACCEL_SENS = 8'h14;
   localparam logic [7:0] CMD_GYRO_SENS = 8'h15;
   // ==========================================================
   // Timing, sizes and reset values.
   localparam int CLK_MHZ = 125; // Bus clock rate.
   localparam int READY_US = 4000; // Ready signal after reset.
   localparam int READY_CYCLES = READY_US * CLK_MHZ;
   localparam int PULSE_NS = 40; // Edge-mode pulse width.
   localparam int PULSE_CYCLES = (PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam logic [7:0] FIFO_DEPTH = 8'h80; // Entries.
   localparam logic [15:0] BASE_SCALE = 16'h1000; // Base factor.
   localparam int TRIM_FRAC = 13; // Fraction bits of a trim.
   // ==========================================================
   // Types.
   typedef enum logic [1:0] {
      SYNC_ARMED = 2'b00,
      SYNC_SHOWN = 2'b01,
      SYNC_FROZEN = 2'b10
   } sync_state_t;
   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
   } bus_req_t;
endpackage

/* hdl/imu_host_irq.sv */
// Host interrupt lines and command execution of the inertial sensor.
// Assumes one AHB-Lite master, a same-clock sample datapath and an
// output-rate clock pin that this clock samples.
//
// The AHB-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module imu_host_irq #(
   parameter int READY_CYCLES = imu_pkg::READY_CYCLES
) (
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave port.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Sensor side.
   input wire logic output_rate_clk,
   input wire logic [15:0] sample_data,
   input wire logic selftest_ready,
   // Interrupt lines.
   output logic interrupt_line_one,
   output logic data_interrupt_line,
   // Control towards the sensor blocks.
   output logic fifo_clear,
   output logic blocks_on,
   output logic accel_run,
   output logic slow_clock_select,
   output logic [15:0] wake_threshold,
   output logic [15:0] wake_blanking
);
   // ==========================================================
   // State.
   imu_pkg::bus_req_t req_reg, req_next; // Pending data phase.
   logic rd_pend_reg, rd_pend_next; // Read wait state.
   logic [31:0] hrdata_reg, hrdata_next, rdata;
   logic [7:0] cmd_reg, cmd_next; // Last command code.
   logic cmd_go_reg, cmd_go_next; // Command to execute.
   logic done_reg, done_next; // Command done flag.
   logic interrupt_line_one_cmd_reg, interrupt_line_one_cmd_next; // Command wants line one.
   logic [18:0] ready_reg, ready_next; // Ready signal countdown.
   logic [15:0] cal_reg [3], cal_next [3]; // Operands.
   logic [7:0] sensor_reg, sensor_next;
   logic [7:0] accel_reg, accel_next;
   logic [7:0] gyro_reg, gyro_next;
   logic [15:0] fifo_reg, fifo_next; // Mode, read bit, watermark.
   logic [7:0] level_reg, level_next; // FIFO fill level.
   logic [15:0] out_reg, out_next; // Output data register.
   logic [15:0] gpend_reg [3], gpend_next [3]; // Waiting trims.
   logic [15:0] apend_reg [3], apend_next [3];
   logic [15:0] gscale_reg [3], gscale_next [3]; // Live scales.
   logic [15:0] ascale_reg [3], ascale_next [3];
   logic [1:0] pend_reg, pend_next; // Bit 0 gyro, bit 1 accel.
   logic [2:0] pulse_reg, pulse_next; // Edge-mode pulse timer.
   imu_pkg::sync_state_t sync_reg, sync_next;
   logic fifo_int_reg, fifo_int_next;
   logic st_int_reg, st_int_next;
   logic interrupt_line_one_reg, interrupt_line_one_next, data_interrupt_line_reg, data_interrupt_line_next;
   logic clr_reg, clr_next;
   logic [15:0] wthr_reg, wthr_next, wblk_reg, wblk_next;
   logic rs1_reg, rs2_reg, rs3_reg; // Rate clock synchroniser.
   logic accept, tick, st_any, wm_hit;
   logic [1:0] stab, fmode;

   // Scales a base factor by a 3.13 trim value.
   function automatic logic [15:0] trim_mul(input logic [15:0] base,
                                            input logic [15:0] trim);
      logic [31:0] prod;
      prod = base * trim;
      return prod[imu_pkg::TRIM_FRAC +: 16];
   endfunction

   // Byte offset of word idx of a register group.
   function automatic logic [7:0] word_ofs(input logic [7:0] base,
                                           input int idx);
      return base + 8'(idx * 4);
   endfunction

   // ==========================================================
   // Rate clock sampling.
   // The pin is asynchronous; only rs2 feeds logic, rs3 finds edges.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rs1_reg <= 1'b0;
         rs2_reg <= 1'b0;
         rs3_reg <= 1'b0;
      end else begin
         rs1_reg <= output_rate_clk;
         rs2_reg <= rs1_reg;
         rs3_reg <= rs2_reg;
      end
   end

   assign tick = rs2_reg & ~rs3_reg;
   assign accept = hsel & hready & htrans[1] & (hsize == 3'b010);
   assign stab = gyro_reg[1:0];
   assign fmode = fifo_reg[1:0];
   assign st_any = accel_reg[imu_pkg::BIT_SELFTEST] |
                   gyro_reg[imu_pkg::BIT_SELFTEST];

   // ==========================================================
   // Next-state logic of bus, commands and interrupts.
   always_comb begin
      req_next = '0;
      rd_pend_next = 1'b0;
      hrdata_next = hrdata_reg;
      rdata = 32'h0000_0000;
      cmd_next = cmd_reg;
      cmd_go_next = 1'b0;
      done_next = done_reg;
      interrupt_line_one_cmd_next = interrupt_line_one_cmd_reg;
      ready_next = (ready_reg != 19'h0) ? ready_reg - 19'h1 : 19'h0;
      cal_next = cal_reg;
      sensor_next = sensor_reg;
      accel_next = accel_reg;
      gyro_next = gyro_reg;
      fifo_next = fifo_reg;
      level_next = level_reg;
      out_next = out_reg;
      gpend_next = gpend_reg;
      apend_next = apend_reg;
      gscale_next = gscale_reg;
      ascale_next = ascale_reg;
      pend_next = pend_reg;
      pulse_next = (pulse_reg != 3'h0) ? pulse_reg - 3'h1 : 3'h0;
      sync_next = sync_reg;
      fifo_int_next = fifo_int_reg;
      clr_next = 1'b0;
      wthr_next = wthr_reg;
      wblk_next = wblk_reg;
      wm_hit = 1'b0;
      // Address phase: only whole-word transfers are taken.
      if (accept) begin
         req_next.addr = haddr[7:0];
         req_next.wr = hwrite;
         req_next.rd = ~hwrite;
         rd_pend_next = ~hwrite;
      end
      // Reads take one wait state so a write just before is seen.
      if (rd_pend_reg) begin
         case (req_reg.addr)
            imu_pkg::OFS_CMD: rdata = {24'h0, cmd_reg};
            imu_pkg::OFS_CMD_STAT: rdata = {31'h0, done_reg};
            imu_pkg::OFS_DATA_STAT:
               rdata = {31'h0, sync_reg == imu_pkg::SYNC_SHOWN};
            imu_pkg::OFS_SENSOR: rdata = {24'h0, sensor_reg};
            imu_pkg::OFS_ACCEL: rdata = {24'h0, accel_reg};
            imu_pkg::OFS_GYRO: rdata = {24'h0, gyro_reg};
            imu_pkg::OFS_FIFO: rdata = {16'h0, fifo_reg};
            imu_pkg::OFS_LEVEL: rdata = {24'h0, level_reg};
            imu_pkg::OFS_OUT: rdata = {16'h0, out_reg};
            default: rdata = 32'h0000_0000;
         endcase
         for (int i = 0; i < 3; i++) begin
            if (req_reg.addr == word_ofs(imu_pkg::OFS_CAL, i)) begin
               rdata = {16'h0, cal_reg[i]};
            end
            if (req_reg.addr == word_ofs(imu_pkg::OFS_GSCALE, i)) begin
               rdata = {16'h0, gscale_reg[i]};
            end
            if (req_reg.addr == word_ofs(imu_pkg::OFS_ASCALE, i)) begin
               rdata = {16'h0, ascale_reg[i]};
            end
         end
         hrdata_next = rdata;
         // Both normal-mode causes of line one, ready and command done, are withdrawn by this read.
         if (req_reg.addr == imu_pkg::OFS_CMD_STAT) begin
            interrupt_line_one_cmd_next = 1'b0;
            ready_next = 19'h0;
         end
         if (req_reg.addr == imu_pkg::OFS_DATA_STAT &&
             sync_reg == imu_pkg::SYNC_SHOWN) begin
            sync_next = imu_pkg::SYNC_FROZEN;
         end
         // Reading the output word is the last byte of the set.
         if (req_reg.addr == imu_pkg::OFS_OUT &&
             sync_reg == imu_pkg::SYNC_FROZEN) begin
            sync_next = imu_pkg::SYNC_ARMED;
         end
      end
      // Write data phase.
      if (req_reg.wr) begin
         case (req_reg.addr)
            imu_pkg::OFS_CMD: begin
               cmd_next = hwdata[7:0];
               cmd_go_next = 1'b1;
               done_next = 1'b0;
            end
            imu_pkg::OFS_SENSOR: sensor_next = hwdata[7:0];
            imu_pkg::OFS_ACCEL: accel_next = hwdata[7:0];
            imu_pkg::OFS_GYRO: gyro_next = hwdata[7:0];
            imu_pkg::OFS_FIFO: begin
               fifo_next = hwdata[15:0];
               // The host has drained the FIFO and leaves read mode.
               if (fifo_reg[imu_pkg::BIT_FIFO_RD] &&
                   !hwdata[imu_pkg::BIT_FIFO_RD]) begin
                  fifo_int_next = 1'b0;
                  level_next = 8'h00;
               end
            end
            default: begin
            end
         endcase
         for (int i = 0; i < 3; i++) begin
            if (req_reg.addr == word_ofs(imu_pkg::OFS_CAL, i)) begin
               cal_next[i] = hwdata[15:0];
            end
         end
      end
      // Command execution; the operands were loaded beforehand.
      if (cmd_go_reg) begin
         case (cmd_reg)
            imu_pkg::CMD_RST_FIFO: begin
               level_next = 8'h00;
               clr_next = 1'b1;
            end
            imu_pkg::CMD_WAKE: begin
               wthr_next = cal_reg[0];
               wblk_next = cal_reg[1];
            end
            imu_pkg::CMD_GYRO_SENS: begin
               for (int i = 0; i < 3; i++) begin
                  gpend_next[i] = trim_mul(imu_pkg::BASE_SCALE,
                                           cal_reg[i]);
               end
               pend_next[0] = 1'b1;
            end
            imu_pkg::CMD_ACCEL_SENS: begin
               for (int i = 0; i < 3; i++) begin
                  apend_next[i] = trim_mul(imu_pkg::BASE_SCALE,
                                           cal_reg[i]);
               end
               pend_next[1] = 1'b1;
            end
            default: begin
               // Unknown codes change no setting; done and line one are still raised below.
            end
         endcase
         // Set after the read clear, so a new done is never lost.
         done_next = 1'b1;
         interrupt_line_one_cmd_next = 1'b1;
      end
      // Output-rate tick; power-down halts it but keeps registers.
      if (tick && !sensor_reg[imu_pkg::BIT_SENSOR_OFF]) begin
         // New trims land on the first sample after the command.
         // A trim issued in this same cycle stays pending for the next.
         if (pend_reg[0]) begin
            gscale_next = gpend_reg;
            pend_next[0] = cmd_go_reg && cmd_reg == imu_pkg::CMD_GYRO_SENS;
         end
         if (pend_reg[1]) begin
            ascale_next = apend_reg;
            pend_next[1] = cmd_go_reg && cmd_reg == imu_pkg::CMD_ACCEL_SENS;
         end
         if (sync_reg != imu_pkg::SYNC_FROZEN) begin
            out_next = sample_data;
         end
         if (sensor_reg[imu_pkg::BIT_SYNC_SEL]) begin
            if (sync_reg == imu_pkg::SYNC_ARMED) begin
               sync_next = imu_pkg::SYNC_SHOWN;
            end
         end else begin
            pulse_next = 3'(imu_pkg::PULSE_CYCLES);
         end
         // Stop mode stalls at full, stream mode overwrites; either
         // way the count saturates at the depth.
         if (fmode != 2'b00 && level_next != imu_pkg::FIFO_DEPTH) begin
            level_next = level_next + 8'h01;
         end
         wm_hit = (fifo_reg[15:8] != 8'h00) &&
                  (level_next >= fifo_reg[15:8]);
         if (fmode == imu_pkg::FIFO_STOP &&
             (wm_hit || level_next == imu_pkg::FIFO_DEPTH)) begin
            fifo_int_next = 1'b1;
         end
         if (fmode == imu_pkg::FIFO_STREAM && wm_hit) begin
            fifo_int_next = 1'b1;
         end
      end
      if (!sensor_reg[imu_pkg::BIT_SYNC_SEL]) begin
         sync_next = imu_pkg::SYNC_ARMED;
      end
      // Self-test result flag lives while either enable is set.
      st_int_next = st_any & (st_int_reg | selftest_ready);
      // Line one: rate clock in stabilization mode, else normal uses.
      if (stab == imu_pkg::STAB_OIS) begin
         interrupt_line_one_next = rs2_reg;
      end else begin
         interrupt_line_one_next = (ready_reg != 19'h0) | interrupt_line_one_cmd_reg;
      end
      // Data line: one source at a time, in this priority.
      if (stab == imu_pkg::STAB_LL) begin
         data_interrupt_line_next = rs2_reg;
      end else if (st_any) begin
         data_interrupt_line_next = st_int_reg;
      end else if (fmode != 2'b00) begin
         data_interrupt_line_next = fifo_int_reg;
      end else if (sensor_reg[imu_pkg::BIT_SYNC_SEL]) begin
         data_interrupt_line_next = (sync_reg == imu_pkg::SYNC_SHOWN);
      end else begin
         data_interrupt_line_next = (pulse_reg != 3'h0);
      end
   end

   // ==========================================================
   // Registers of the block.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         req_reg <= '0;
         rd_pend_reg <= 1'b0;
         hrdata_reg <= 32'h0000_0000;
         cmd_reg <= 8'h00;
         cmd_go_reg <= 1'b0;
         done_reg <= 1'b0;
         interrupt_line_one_cmd_reg <= 1'b0;
         ready_reg <= 19'(READY_CYCLES);
         sensor_reg <= 8'h00;
         accel_reg <= 8'h00;
         gyro_reg <= 8'h00;
         fifo_reg <= 16'h0000;
         level_reg <= 8'h00;
         out_reg <= 16'h0000;
         pend_reg <= 2'b00;
         pulse_reg <= 3'h0;
         sync_reg <= imu_pkg::SYNC_ARMED;
         fifo_int_reg <= 1'b0;
         st_int_reg <= 1'b0;
         interrupt_line_one_reg <= 1'b0;
         data_interrupt_line_reg <= 1'b0;
         clr_reg <= 1'b0;
         wthr_reg <= 16'h0000;
         wblk_reg <= 16'h0000;
         for (int i = 0; i < 3; i++) begin
            cal_reg[i] <= 16'h0000;
            gpend_reg[i] <= imu_pkg::BASE_SCALE;
            apend_reg[i] <= imu_pkg::BASE_SCALE;
            gscale_reg[i] <= imu_pkg::BASE_SCALE;
            ascale_reg[i] <= imu_pkg::BASE_SCALE;
         end
      end else begin
         req_reg <= req_next;
         rd_pend_reg <= rd_pend_next;
         hrdata_reg <= hrdata_next;
         cmd_reg <= cmd_next;
         cmd_go_reg <= cmd_go_next;
         done_reg <= done_next;
         interrupt_line_one_cmd_reg <= interrupt_line_one_cmd_next;
         ready_reg <= ready_next;
         sensor_reg <= sensor_next;
         accel_reg <= accel_next;
         gyro_reg <= gyro_next;
         fifo_reg <= fifo_next;
         level_reg <= level_next;
         out_reg <= out_next;
         pend_reg <= pend_next;
         pulse_reg <= pulse_next;
         sync_reg <= sync_next;
         fifo_int_reg <= fifo_int_next;
         st_int_reg <= st_int_next;
         interrupt_line_one_reg <= interrupt_line_one_next;
         data_interrupt_line_reg <= data_interrupt_line_next;
         clr_reg <= clr_next;
         wthr_reg <= wthr_next;
         wblk_reg <= wblk_next;
         cal_reg <= cal_next;
         gpend_reg <= gpend_next;
         apend_reg <= apend_next;
         gscale_reg <= gscale_next;
         ascale_reg <= ascale_next;
      end
   end

   // ==========================================================
   // Outputs.
   assign hreadyout = ~rd_pend_reg;
   assign hresp = 1'b0;
   assign hrdata = hrdata_reg;
   assign interrupt_line_one = interrupt_line_one_reg;
   assign data_interrupt_line = data_interrupt_line_reg;
   assign fifo_clear = clr_reg;
   assign wake_threshold = wthr_reg;
   assign wake_blanking = wblk_reg;
   assign blocks_on = ~sensor_reg[imu_pkg::BIT_SENSOR_OFF];
   // The accelerometer is unavailable in plain stabilization mode.
   assign accel_run = sensor_reg[0] & blocks_on &
                      (stab != imu_pkg::STAB_OIS);
   assign slow_clock_select = accel_reg[imu_pkg::BIT_RATE_TOP];

   // ==========================================================
   // Checks.
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence edge_pulse_s;
      data_interrupt_line [*5] ##1 !data_interrupt_line;
   endsequence

   fifo_reset_a: assert property (
      cmd_go_reg && cmd_reg == imu_pkg::CMD_RST_FIFO |=>
      level_reg <= 8'h01 && fifo_clear)
      else $error("fifo reset did not empty fifo");
   cmd_done_a: assert property (
      cmd_go_reg |=> done_reg && interrupt_line_one_cmd_reg ##1 interrupt_line_one ||
      stab == imu_pkg::STAB_OIS)
      else $error("command did not complete");
   ready_line_a: assert property (
      ready_reg != 19'h0 && stab != imu_pkg::STAB_OIS |=>
      interrupt_line_one)
      else $error("ready signal missing after reset");
   interrupt_line_one_clear_a: assert property (
      rd_pend_reg && req_reg.addr == imu_pkg::OFS_CMD_STAT &&
      !cmd_go_reg && stab != imu_pkg::STAB_OIS ##1 !cmd_go_reg &&
      stab != imu_pkg::STAB_OIS |=> !interrupt_line_one)
      else $error("status read did not drop line one");
   ois_line_a: assert property (
      stab == imu_pkg::STAB_OIS |=>
      interrupt_line_one == $past(rs2_reg))
      else $error("line one not following rate clock");
   edge_pulse_a: assert property (
      tick && sensor_reg == 8'h00 && stab == 2'b00 && !st_any &&
      fmode == 2'b00 |-> ##2 edge_pulse_s)
      else $error("edge mode pulse wrong");
   level_freeze_a: assert property (
      rd_pend_reg && req_reg.addr == imu_pkg::OFS_DATA_STAT &&
      sync_reg == imu_pkg::SYNC_SHOWN |=>
      sync_reg == imu_pkg::SYNC_FROZEN ##1 $stable(out_reg))
      else $error("status read did not freeze outputs");
   trim_apply_a: assert property (
      pend_reg[0] && tick && blocks_on |=>
      gscale_reg[0] == $past(gpend_reg[0]) &&
      pend_reg[0] == ($past(cmd_go_reg) &&
                      $past(cmd_reg) == imu_pkg::CMD_GYRO_SENS))
      else $error("gyro trim not applied");
   power_down_a: assert property (
      !blocks_on |=> $stable(out_reg) && $stable(gscale_reg[0]))
      else $error("power-down changed outputs");
endmodule
`default_nettype wire

/* test/rate_source.sv */
// Sensor-side stand-in: the output-rate clock pin and a moving sample.
// Assumes the block samples the rate pin with its own bus clock.
`timescale 1ns/1ns
`default_nettype none
module rate_source (
   // Pins towards the block.
   output logic output_rate_clk,
   output logic [15:0] sample_data
);
   // The rate clock runs free at a 160 ns period, unrelated to hclk.
   initial output_rate_clk = 1'b0;
   initial sample_data = 16'h0000;
   always #80 output_rate_clk = ~output_rate_clk;
   // The sample steps once per tick so a frozen output can be told apart.
   always @(posedge output_rate_clk) sample_data <= sample_data + 16'h0001;
endmodule
`default_nettype wire

/* test/imu_host_interrupt_and_command_tb.sv */
// Self-checking bench of the host interrupt and command block.
// Assumes a single AHB-Lite master (this bench) and the rate source model.
`timescale 1ns/1ns
`default_nettype none
module imu_host_interrupt_and_command_tb;
   // ==========================================================
   // Signals; the bench is the only bus master.
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hwrite = 1'b0;
   logic st_rdy = 1'b0;
   logic [1:0] htrans = 2'b00;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r, keep;
   logic hrdy, hresp, rclk, line1, dline, fclr, bon, arun, slow;
   logic [15:0] smp, thr, blank;
   logic [15:0] op [3];
   int n_fail = 0, compares = 0, seed = 47, nclr = 0;
   always #4 hclk = ~hclk;
   // Count clear pulses; a stuck-high pulse shows up as more than one.
   always @(posedge hclk) if (fclr === 1'b1) nclr++;
   rate_source i_src (.output_rate_clk(rclk), .sample_data(smp));
   imu_host_irq #(.READY_CYCLES(50)) i_dut (.hclk(hclk), .hresetn(hresetn),
      .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'b010), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy),
      .hresp(hresp), .hrdata(hrdata), .output_rate_clk(rclk),
      .sample_data(smp), .selftest_ready(st_rdy), .interrupt_line_one(line1),
      .data_interrupt_line(dline), .fifo_clear(fclr), .blocks_on(bon),
      .accel_run(arun), .slow_clock_select(slow), .wake_threshold(thr),
      .wake_blanking(blank));
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t saw %h want %h", $time, got, exp);
      end
   endtask
   // Bounded wait for bus ready, sampled before the edge's updates land.
   task automatic rdy;
      int k;
      k = 0;
      do begin
         @(posedge hclk);
         k++;
      end while (hrdy !== 1'b1 && k < 50);
      if (hrdy !== 1'b1) begin
         n_fail++;
         tally_and_finish;
      end
   endtask
   // One whole-word transfer; read data lands in r.
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
      @(posedge hclk);
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h000000, a};
      rdy;
      htrans <= 2'b00;
      hwdata <= d;
      rdy;
      r = hrdata;
   endtask
   // Bounded wait for a line (0 first line, 1 data line) to reach v.
   task automatic wt(input int s, input logic v);
      int k;
      k = 0;
      while (((s == 0) ? line1 : dline) !== v && k < 3000) begin
         @(posedge hclk);
         k++;
      end
      if (((s == 0) ? line1 : dline) !== v) begin
         n_fail++;
         tally_and_finish;
      end
   endtask
   // Issue a command and run the done handshake a host would.
   task automatic cmd(input logic [7:0] c);
      xfer(1'b1, imu_pkg::OFS_CMD, {24'h000000, c});
      wt(0, 1'b1);
      xfer(1'b0, imu_pkg::OFS_CMD_STAT, 32'h0);
      chk({31'h0, r[0]}, 32'h1);
      repeat (3) @(posedge hclk);
      chk({31'h0, line1}, 32'h0);
   endtask
   function automatic logic [31:0] scale(input logic [15:0] v);
      logic [31:0] p;
      p = ({16'h0, imu_pkg::BASE_SCALE} * {16'h0, v}) >> imu_pkg::TRIM_FRAC;
      return {16'h0000, p[15:0]};
   endfunction
   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (3) @(posedge hclk);
      chk({31'h0, line1}, 32'h1);
      xfer(1'b0, imu_pkg::OFS_CMD_STAT, 32'h0);
      repeat (3) @(posedge hclk);
      chk({31'h0, line1}, 32'h0);
      xfer(1'b0, 8'hf0, 32'h0);
      chk(r, 32'h0);
      chk({31'h0, hresp}, 32'h0);
      cmd(8'h7e);
      cmd(imu_pkg::CMD_RST_FIFO);
      chk(nclr, 1);
      xfer(1'b0, imu_pkg::OFS_LEVEL, 32'h0);
      chk(r, 32'h0);
      $display("command tests done");
      // Random operands; the top bit stays clear to keep trims positive.
      for (int c = 0; c < 3; c++) begin
         for (int a = 0; a < 3; a++) begin
            op[a] = 16'($random(seed)) & 16'h7fff;
            xfer(1'b1, imu_pkg::OFS_CAL + 8'(4 * a), {16'h0, op[a]});
         end
         if (c == 0) begin
            cmd(imu_pkg::CMD_WAKE);
            chk({16'h0, thr}, {16'h0, op[0]});
            chk({16'h0, blank}, {16'h0, op[1]});
            continue;
         end
         cmd(c == 1 ? imu_pkg::CMD_GYRO_SENS :
             imu_pkg::CMD_ACCEL_SENS);
         wt(1, 1'b1);
         wt(1, 1'b0);
         wt(1, 1'b1);
         for (int a = 0; a < 3; a++) begin
            xfer(1'b0, (c == 1 ? imu_pkg::OFS_GSCALE : imu_pkg::OFS_ASCALE)
                 + 8'(4 * a), 32'h0);
            chk(r, scale(op[a]));
         end
      end
      $display("trim tests done");
      // Edge mode: a short pulse per tick that clears by itself.
      wt(1, 1'b1);
      repeat (8) @(posedge hclk);
      chk({31'h0, dline}, 32'h0);
      // Level mode: held until status read, frozen until output read.
      xfer(1'b1, imu_pkg::OFS_SENSOR, 32'h80);
      wt(1, 1'b1);
      repeat (60) @(posedge hclk);
      chk({31'h0, dline}, 32'h1);
      xfer(1'b0, imu_pkg::OFS_DATA_STAT, 32'h0);
      repeat (60) @(posedge hclk);
      chk({31'h0, dline}, 32'h0);
      xfer(1'b0, imu_pkg::OFS_OUT, 32'h0);
      wt(1, 1'b1);
      xfer(1'b1, imu_pkg::OFS_SENSOR, 32'h0);
      $display("data line tests done");
      // Self-test in stop mode: an empty FIFO leaves its flag clear.
      xfer(1'b1, imu_pkg::OFS_FIFO, 32'h1);
      xfer(1'b1, imu_pkg::OFS_ACCEL, 32'h80);
      st_rdy <= 1'b1;
      @(posedge hclk);
      st_rdy <= 1'b0;
      wt(1, 1'b1);
      xfer(1'b1, imu_pkg::OFS_ACCEL, 32'h0);
      repeat (3) @(posedge hclk);
      chk({31'h0, dline}, 32'h0);
      // Stream mode runs past full with no flag; stop mode flags full.
      xfer(1'b1, imu_pkg::OFS_FIFO, 32'h2);
      repeat (2700) @(posedge hclk);
      chk({31'h0, dline}, 32'h0);
      xfer(1'b1, imu_pkg::OFS_FIFO, 32'h1);
      wt(1, 1'b1);
      xfer(1'b1, imu_pkg::OFS_FIFO, 32'h81);
      xfer(1'b1, imu_pkg::OFS_FIFO, 32'h1);
      repeat (3) @(posedge hclk);
      chk({31'h0, dline}, 32'h0);
      xfer(1'b1, imu_pkg::OFS_FIFO, 32'h202);
      wt(1, 1'b1);
      $display("fifo tests done");
      // Stabilization modes hand the lines to the rate clock.
      xfer(1'b1, imu_pkg::OFS_SENSOR, 32'h1);
      xfer(1'b1, imu_pkg::OFS_GYRO, 32'h1);
      @(posedge hclk);
      chk({31'h0, arun}, 32'h0);
      wt(0, 1'b1);
      wt(0, 1'b0);
      xfer(1'b1, imu_pkg::OFS_GYRO, 32'h2);
      @(posedge hclk);
      chk({31'h0, arun}, 32'h1);
      wt(1, 1'b0);
      wt(1, 1'b1);
      xfer(1'b1, imu_pkg::OFS_GYRO, 32'h0);
      $display("stabilization tests done");
      // Power-down keeps registers; the rate top bit picks the slow clock.
      xfer(1'b1, imu_pkg::OFS_SENSOR, 32'h40);
      xfer(1'b1, imu_pkg::OFS_ACCEL, 32'h8);
      // The write lands at the edge the transfer ends on; look one later.
      @(posedge hclk);
      chk({31'h0, bon}, 32'h0);
      chk({31'h0, slow}, 32'h1);
      xfer(1'b0, imu_pkg::OFS_ASCALE, 32'h0);
      chk(r, scale(op[0]));
      // Ticks keep coming, yet the output word must not move.
      xfer(1'b0, imu_pkg::OFS_OUT, 32'h0);
      keep = r;
      repeat (60) @(posedge hclk);
      xfer(1'b0, imu_pkg::OFS_OUT, 32'h0);
      chk(r, keep);
      $display("power tests done");
      tally_and_finish;
   end
endmodule
`default_nettype wire
